// *** core/amp_supervision.v ***
// supervision, ripple calibration sequencer and general-purpose pin control
`timescale 1ns/1ps
`include "amp_supervision_defines.vh"

module amp_supervision #(
   parameter NUM_PINS       = 7,
   parameter CLIP_CYCLES    = `CLIP_CYCLES,
   parameter FULL_CYCLES    = `FULL_CAL_CYCLES,
   parameter QUICK_CYCLES   = `QUICK_CAL_CYCLES,
   parameter SCHED_CYCLES   = `SCHED_CYCLES
) (
   // clock and reset
   input  wire                sys_clk,
   input  wire                arst_n,
   input  wire                softReset,
   // register port behind the serial host interface
   input  wire                regWr,
   input  wire                regRd,
   input  wire [3:0]          regAddr,
   input  wire [7:0]          regWrData,
   output reg  [7:0]          regRdData,
   // analog monitors
   input  wire                inClipA,
   input  wire                inClipB,
   input  wire                outSatPos,
   input  wire                outSatNeg,
   input  wire                hvPosLow,
   input  wire                hvNegLow,
   // analog controls
   output reg  [3:0]          inputGain,
   output reg  [1:0]          scaleSel,
   output reg  [5:0]          switchCtl,
   output reg                 calBusy,
   output reg                 calQuick,
   output reg  [3:0]          calAmpIdx,
   output reg                 extClkUse,
   // general-purpose pins
   input  wire                hostCs_n,
   input  wire [NUM_PINS-1:0] gpioIn,
   output reg  [NUM_PINS-1:0] gpioOut,
   output reg  [NUM_PINS-1:0] gpioOe_n
);

   // ----------------------------------------------------------------------------
   // state and registers
   // ----------------------------------------------------------------------------
   localparam ST_IDLE = 1'b0;      // no calibration running
   localparam ST_RUN  = 1'b1;      // calibration in progress

   reg [7:0]          gainReg;     // gain, scale bits and external mux field
   reg [7:0]          ctlReg;      // control bits
   reg [NUM_PINS-1:0] pinDir;      // 1 = output
   reg [NUM_PINS-1:0] pinVal;      // output values
   reg [NUM_PINS-1:0] chainSel;    // chained select enables
   reg [4:0]          sfCfg;       // special function enables
   reg [5:0]          swReg;       // switch settings kept by software
   reg                inClip;      // input clip flag
   reg                gainRestored;// sticky restore flag
   reg                outClip;     // output clip flag
   reg                hvLow;       // sticky supply-low flag
   reg                hvLowPrev;   // for rising-edge detect
   reg [15:0]         clipCnt;     // cycles of continuous input clip
   reg                calState;    // sequencer state
   reg [23:0]         calCnt;      // cycles left in current run / step
   reg [31:0]         schedCnt;    // scheduled calibration timer
   reg                pendFull;    // an automatic full run is owed
   reg [6:0]          mclkCnt;     // master clock divider
   reg [9:0]          chopCnt;     // chopping clock divider
   reg                mclk;        // 1 MHz master clock
   reg                chopClk;     // 125 kHz chopping clock

   localparam [31:0] FULL_STEP = FULL_CYCLES / `NUM_AMPS; // cycles per amplifier step
   wire [23:0] fullStep = FULL_STEP[23:0]; // a remainder below one cycle per step is dropped

   // schedule interval: unit, doubled per field step
   function [31:0] schedLimit;
      input [1:0] field;
      begin
         schedLimit = SCHED_CYCLES[31:0] << (field - 2'd1);
      end
   endfunction

   wire hvNow      = hvPosLow | hvNegLow;
   wire clipNow    = inClipA | inClipB;
   wire anyFault   = inClip | gainRestored | outClip | hvLow;
   wire wrGain     = regWr & (regAddr == `REG_GAIN);
   wire wrCtl      = regWr & (regAddr == `REG_CONTROL);
   wire wrStatus   = regWr & (regAddr == `REG_STATUS);
   wire clipLong   = (clipCnt >= CLIP_CYCLES[15:0]);
   wire doRestore  = clipLong & ~ctlReg[`CTL_RESTORE_DIS];
   wire [1:0] schedField = ctlReg[`CTL_SCHED_HI:`CTL_SCHED_LO];
   wire schedHit   = (schedField != 2'd0) && (schedCnt >= schedLimit(schedField));
   wire trigHit    = ctlReg[`CTL_CAL_TRIGGER];

   // ----------------------------------------------------------------------------
   // register writes, flags and gain protection
   // ----------------------------------------------------------------------------
   // soft reset returns every software setting to its reset value
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         gainReg      <= `GAIN_RESET;
         ctlReg       <= 8'h00;
         pinDir       <= {NUM_PINS{1'b0}};
         pinVal       <= {NUM_PINS{1'b0}};
         chainSel     <= {NUM_PINS{1'b0}};
         sfCfg        <= 5'h00;
         swReg        <= `SWITCH_RESET;
         inClip       <= 1'b0;
         gainRestored <= 1'b0;
         outClip      <= 1'b0;
         hvLow        <= 1'b0;
         hvLowPrev    <= 1'b0;
         clipCnt      <= 16'h0000;
      end else if (softReset) begin
         gainReg      <= `GAIN_RESET;
         ctlReg       <= 8'h00;
         pinDir       <= {NUM_PINS{1'b0}};
         pinVal       <= {NUM_PINS{1'b0}};
         chainSel     <= {NUM_PINS{1'b0}};
         sfCfg        <= 5'h00;
         swReg        <= `SWITCH_RESET;
         gainRestored <= 1'b0;
         hvLow        <= 1'b0;
         clipCnt      <= 16'h0000;
      end else begin
         inClip    <= clipNow;
         outClip   <= outSatPos | outSatNeg;
         hvLowPrev <= hvNow;
         // counter saturates so a stuck clip keeps the restore asserted
         if (!clipNow)
            clipCnt <= 16'h0000;
         else if (!clipLong)
            clipCnt <= clipCnt + 16'h0001;
         // gain register: restore wins over a software write
         if (doRestore)
            gainReg <= (gainReg & 8'hc0) | (`GAIN_RESET & 8'h3f);
         else if (wrGain)
            gainReg <= regWrData;
         // control: trigger self-clears the cycle after its write, whether the sequencer takes it or not
         if (wrCtl)
            ctlReg <= {2'b00, regWrData[5:0]};
         else if (calState == ST_IDLE)
            ctlReg[`CTL_CAL_TRIGGER] <= 1'b0;
         else if (trigHit)
            ctlReg[`CTL_CAL_TRIGGER] <= 1'b0;
         // sticky flags: a new event wins over the write-one clear
         if (doRestore)
            gainRestored <= 1'b1;
         else if (wrStatus && regWrData[`ST_GAIN_RESTORED])
            gainRestored <= 1'b0;
         if (hvNow)
            hvLow <= 1'b1;
         else if (wrStatus && regWrData[`ST_HV_LOW])
            hvLow <= 1'b0;
         if (regWr && regAddr == `REG_PIN_DIR)
            pinDir <= regWrData[NUM_PINS-1:0];
         if (regWr && regAddr == `REG_PIN_VALUE)
            pinVal <= regWrData[NUM_PINS-1:0];
         if (regWr && regAddr == `REG_CHAIN_SEL)
            chainSel <= regWrData[NUM_PINS-1:0];
         if (regWr && regAddr == `REG_SPECIAL_FUNCTION_CFG)
            sfCfg <= regWrData[4:0];
         if (regWr && regAddr == `REG_SWITCH)
            swReg <= regWrData[5:0];
      end
   end

   // ----------------------------------------------------------------------------
   // calibration sequencer
   // ----------------------------------------------------------------------------
   // a full run owed while running is held until idle and started then; a
   // trigger seen while running is dropped, since the run already renulls
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         calState  <= ST_IDLE;
         calCnt    <= 24'h000000;
         calQuick  <= 1'b0;
         calAmpIdx <= 4'h0;
         schedCnt  <= 32'h00000000;
         pendFull  <= 1'b1;
      end else begin
         if (softReset || (hvNow && !hvLowPrev))
            pendFull <= 1'b1;
         if (calState == ST_RUN || schedField == 2'd0 || schedHit)
            schedCnt <= 32'h00000000;
         else
            schedCnt <= schedCnt + 32'h00000001;
         case (calState)
            ST_IDLE: begin
               calAmpIdx <= 4'h0;
               if (pendFull && !softReset) begin
                  pendFull  <= 1'b0;
                  calQuick  <= 1'b0;
                  calCnt    <= fullStep;
                  calState  <= ST_RUN;
               end else if (trigHit || schedHit) begin
                  calQuick  <= ctlReg[`CTL_CAL_QUICK];
                  calCnt    <= ctlReg[`CTL_CAL_QUICK] ? QUICK_CYCLES[23:0]
                                                      : fullStep;
                  calState  <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (softReset) begin
                  calState <= ST_IDLE;
               end else if (calCnt > 24'h000001) begin
                  calCnt <= calCnt - 24'h000001;
               end else if (!calQuick && calAmpIdx != `NUM_AMPS - 1) begin
                  calAmpIdx <= calAmpIdx + 4'h1;
                  calCnt    <= fullStep;
               end else begin
                  calState <= ST_IDLE;
               end
            end
            default: calState <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // clock dividers for export
   // ----------------------------------------------------------------------------
   // the odd 125-cycle period gives a near-half duty cycle, fine for sync use
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mclkCnt <= 7'h00;
         chopCnt <= 10'h000;
         mclk    <= 1'b0;
         chopClk <= 1'b0;
      end else begin
         mclkCnt <= (mclkCnt == `MCLK_PERIOD - 1) ? 7'h00 : mclkCnt + 7'h01;
         chopCnt <= (chopCnt == `CHOP_PERIOD - 1) ? 10'h000 : chopCnt + 10'h001;
         mclk    <= (mclkCnt < `MCLK_HALF);
         chopClk <= (chopCnt < `CHOP_HALF);
      end
   end

   // ----------------------------------------------------------------------------
   // analog control and pin outputs
   // ----------------------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < NUM_PINS; p = p + 1) begin : gPin
         // special functions take priority over chaining, then plain data
         always @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               gpioOut[p]  <= 1'b0;
               gpioOe_n[p] <= 1'b1;
            end else begin
               gpioOe_n[p] <= ~pinDir[p];
               if (p <= 1 && sfCfg[`SF_EXTERNAL_MUX_FIELD])
                  gpioOut[p] <= gainReg[6 + (p % 2)];
               else if (p == 2 && sfCfg[`SF_CAL_BUSY])
                  gpioOut[p] <= (calState == ST_RUN);
               else if (p == 3 && sfCfg[`SF_FAULT])
                  gpioOut[p] <= anyFault;
               else if (p == 4 && sfCfg[`SF_CLK_OUT] && !sfCfg[`SF_CLK_IN])
                  gpioOut[p] <= ctlReg[`CTL_CLK_SEL] ? chopClk : mclk;
               else if (chainSel[p])
                  gpioOut[p] <= hostCs_n;
               else
                  gpioOut[p] <= pinVal[p];
            end
         end
      end
   endgenerate

   // switches forced while calibrating; software values return afterwards
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         inputGain <= 4'h0;
         scaleSel  <= 2'b00;
         switchCtl <= `SWITCH_RESET;
         calBusy   <= 1'b0;
         extClkUse <= 1'b0;
      end else begin
         inputGain <= gainReg[3:0];
         scaleSel  <= gainReg[5:4];
         calBusy   <= (calState == ST_RUN);
         extClkUse <= sfCfg[`SF_CLK_IN] & ~sfCfg[`SF_CLK_OUT] & ~pinDir[4];
         if (calState == ST_RUN)
            switchCtl <= {2'b11, 4'b0000};
         else
            switchCtl <= swReg;
      end
   end

   // ----------------------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------------------
   // pin value read mixes stored outputs and sampled inputs per direction
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            `REG_GAIN:      regRdData <= gainReg;
            `REG_CONTROL:   regRdData <= ctlReg;
            `REG_STATUS:    regRdData <= {3'b000, calState == ST_RUN, hvLow,
                                          outClip, gainRestored, inClip};
            `REG_PIN_DIR:   regRdData <= {{(8-NUM_PINS){1'b0}}, pinDir};
            `REG_PIN_VALUE: regRdData <= {{(8-NUM_PINS){1'b0}},
                                          (pinDir & pinVal) | (~pinDir & gpioIn)};
            `REG_CHAIN_SEL: regRdData <= {{(8-NUM_PINS){1'b0}}, chainSel};
            `REG_SPECIAL_FUNCTION_CFG:    regRdData <= {3'b000, sfCfg};
            `REG_SWITCH:    regRdData <= {2'b00, swReg};
            default:        regRdData <= 8'h00;
         endcase
      end
   end

endmodule // amp_supervision

// *** core/amp_supervision_defines.vh ***
// constants for the amplifier supervision, calibration and pin control block
`ifndef AMP_SUPERVISION_DEFINES_VH
`define AMP_SUPERVISION_DEFINES_VH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS    8
`define CLIP_TIME_NS     200000
`define CLIP_CYCLES      ((`CLIP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FULL_CAL_MS      85
`define FULL_CAL_CYCLES  ((`FULL_CAL_MS * 1000000) / `CLK_PERIOD_NS)
`define QUICK_CAL_MS     8
`define QUICK_CAL_CYCLES ((`QUICK_CAL_MS * 1000000) / `CLK_PERIOD_NS)
`define SCHED_UNIT_MS    1000
`define SCHED_CYCLES     ((`SCHED_UNIT_MS * 1000000) / `CLK_PERIOD_NS)
`define MCLK_NS          1000
`define MCLK_HALF        ((`MCLK_NS / `CLK_PERIOD_NS) / 2)
`define MCLK_PERIOD      (`MCLK_NS / `CLK_PERIOD_NS)
`define CHOP_NS          8000
`define CHOP_HALF        ((`CHOP_NS / `CLK_PERIOD_NS) / 2)
`define CHOP_PERIOD      (`CHOP_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define REG_GAIN         4'h0
`define REG_CONTROL      4'h1
`define REG_STATUS       4'h2
`define REG_PIN_DIR      4'h3
`define REG_PIN_VALUE    4'h4
`define REG_CHAIN_SEL    4'h5
`define REG_SPECIAL_FUNCTION_CFG       4'h6
`define REG_SWITCH       4'h7

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define CTL_RESTORE_DIS  0
`define CTL_CAL_QUICK    1
`define CTL_SCHED_LO     2
`define CTL_SCHED_HI     3
`define CTL_CAL_TRIGGER  4
`define CTL_CLK_SEL      5
`define ST_INPUT_CLIP    0
`define ST_GAIN_RESTORED 1
`define ST_OUTPUT_CLIP   2
`define ST_HV_LOW        3
`define ST_CAL_BUSY      4
`define SF_EXTERNAL_MUX_FIELD       0
`define SF_CAL_BUSY      1
`define SF_FAULT         2
`define SF_CLK_OUT       3
`define SF_CLK_IN        4
`define GAIN_RESET       8'h00
`define SWITCH_RESET     6'h00
`define NUM_AMPS         9

`endif

// *** testbench/amp_supervision_checker.sv ***
// port-level concurrent checks for the supervision block
`timescale 1ns/1ps
module amp_supervision_checker #(
   parameter NUM_PINS     = 7,
   parameter CLIP_CYCLES  = 20,
   parameter FULL_CYCLES  = 90,
   parameter QUICK_CYCLES = 10
) (
   // clock, resets and register writes
   input wire                sys_clk,
   input wire                arst_n,
   input wire                softReset,
   input wire                regWr,
   input wire [3:0]          regAddr,
   input wire [7:0]          regWrData,
   // monitors and analog controls
   input wire                inClipA,
   input wire                inClipB,
   input wire                outSatPos,
   input wire [3:0]          inputGain,
   input wire [1:0]          scaleSel,
   input wire [5:0]          switchCtl,
   input wire                calBusy,
   input wire                calQuick,
   // pins
   input wire                hostCs_n,
   input wire [NUM_PINS-1:0] gpioOut,
   input wire [NUM_PINS-1:0] gpioOe_n
);
   // shadows of the writable registers except status and switch, rebuilt from the write port
   reg [7:0] ctl, gn, sf, dir, val, chn;
   integer   clipCnt, busyLen;   // run lengths of clipping and of busy
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         {ctl, gn, sf, dir, val, chn} <= 48'h0;
      end else if (softReset) begin
         {ctl, gn, sf, dir, val, chn} <= 48'h0;
      end else if (regWr) begin
         case (regAddr)
            4'h0: gn <= regWrData;
            4'h1: ctl <= regWrData;
            4'h3: dir <= regWrData;
            4'h4: val <= regWrData;
            4'h5: chn <= regWrData;
            4'h6: sf <= regWrData;
            default: ;
         endcase
      end
   end
   // counters are not cleared by soft reset: clipping and busy are physical
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         clipCnt <= 0;
         busyLen <= 0;
      end else begin
         clipCnt <= (inClipA || inClipB) ? clipCnt + 1 : 0;
         busyLen <= calBusy ? busyLen + 1 : 0;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   AST_SWITCH_FORCED: assert property (
      $rose(calBusy) |=> (switchCtl == 6'h30) [*3]) else $error("switches not forced");
   AST_CAL_LENGTH: assert property (
      $fell(calBusy) |-> (calQuick ? (busyLen >= QUICK_CYCLES - 1 && busyLen <= QUICK_CYCLES + 1)
         : (busyLen >= FULL_CYCLES - 1 && busyLen <= FULL_CYCLES + 1)))
      else $error("calibration length off");
   AST_AUTO_CAL: assert property (
      softReset |-> ##[1:3] calBusy) else $error("no calibration after soft reset");
   AST_GAIN_RESTORE: assert property (
      clipCnt > CLIP_CYCLES + 3 && !ctl[0] |-> inputGain == 4'h0 && scaleSel == 2'b00)
      else $error("gain not restored");
   AST_RESTORE_OFF: assert property (
      clipCnt > 2 && ctl[0] && !$past(regWr) && !$past(regWr, 2) && !$past(softReset)
      |-> $stable(inputGain))
      else $error("gain changed while restore disabled");
   AST_DIRECTION: assert property (
      dir == $past(dir) && dir == $past(dir, 2) |-> gpioOe_n == ~dir[NUM_PINS-1:0])
      else $error("pin direction mismatch");
   AST_PIN_VALUE: assert property (
      dir[6] && $past(dir[6]) && !chn[6] && val == $past(val) && val == $past(val, 2)
      |-> gpioOut[6] == val[6]) else $error("pin value mismatch");
   AST_CHAIN: assert property (
      chn[5] && dir[5] && $past(chn[5]) && $stable(hostCs_n) |-> gpioOut[5] == hostCs_n)
      else $error("chip select not relayed");
   AST_BUSY_PIN: assert property (
      sf[1] && dir[2] && $past(sf[1]) && $past(dir[2]) && calBusy && $past(calBusy)
      |-> gpioOut[2]) else $error("busy pin low during calibration");
   AST_FAULT_PIN: assert property (
      sf[2] && dir[3] && $past(sf[2]) && $past(outSatPos, 2) && $past(outSatPos, 3)
      && $past(outSatPos, 4) |-> gpioOut[3]) else $error("fault pin low");
   AST_EXTERNAL_MUX_FIELD: assert property (
      sf[0] && dir[1:0] == 2'b11 && $past(sf[0]) && $past(dir[1:0]) == 2'b11 && gn == $past(gn)
      |-> gpioOut[1:0] == {gn[7], gn[6]}) else $error("mux pins mismatch");
endmodule // amp_supervision_checker

bind amp_supervision amp_supervision_checker #(
   .NUM_PINS(NUM_PINS), .CLIP_CYCLES(CLIP_CYCLES), .FULL_CYCLES(FULL_CYCLES),
   .QUICK_CYCLES(QUICK_CYCLES)
) chk_u (
   .sys_clk, .arst_n, .softReset, .regWr, .regAddr, .regWrData, .inClipA, .inClipB,
   .outSatPos, .inputGain, .scaleSel, .switchCtl, .calBusy, .calQuick, .hostCs_n,
   .gpioOut, .gpioOe_n
);

// *** testbench/pin_world.sv ***
// board-side model of the general-purpose pins and their outside sources
`timescale 1ns/1ps
module pin_world (
   // device side of the pads
   input  wire [6:0] gpioOut,
   input  wire [6:0] gpioOe_n,
   // level outside sources put on pins the device leaves alone
   input  wire [6:0] extDrv,
   // resolved pad levels
   output wire [6:0] gpioIn
);
   // a driven pad shows the device's value, otherwise the outside source wins
   assign gpioIn = (gpioOut & ~gpioOe_n) | (extDrv & gpioOe_n);
endmodule // pin_world

// *** testbench/amp_supervision_tb_top.sv ***
// self-checking bench for the supervision block
`timescale 1ns/1ps
`include "amp_supervision_defines.vh"
module amp_supervision_tb_top;
   localparam CLIP = 20, FULL = 90, QUICK = 10, SCHED = 50;
   reg        sys_clk, softReset = 0, regWr = 0, regRd = 0, arst_n = 0, hostCs_n = 1;
   reg        inClipA = 0, inClipB = 0, outSatPos = 0, outSatNeg = 0, hvPosLow = 0, hvNegLow = 0;
   reg  [3:0] regAddr = 4'h0;
   reg  [7:0] regWrData = 8'h00;
   reg  [6:0] extDrv = 7'h00;      // outside sources on undriven pins
   reg [31:0] lfsr = 32'hcded171b;
   wire [7:0] regRdData;
   wire [3:0] inputGain, calAmpIdx;
   wire [1:0] scaleSel;
   wire [5:0] switchCtl;
   wire       calBusy, calQuick, extClkUse;
   wire [6:0] gpioIn, gpioOut, gpioOe_n;
   integer    err_count = 0, checks_done = 0, i, n, t;
   amp_supervision #(.CLIP_CYCLES(CLIP), .FULL_CYCLES(FULL), .QUICK_CYCLES(QUICK),
      .SCHED_CYCLES(SCHED)) dut_u (.sys_clk, .arst_n, .softReset, .regWr, .regRd, .regAddr,
      .regWrData, .regRdData, .inClipA, .inClipB, .outSatPos, .outSatNeg, .hvPosLow,
      .hvNegLow, .inputGain, .scaleSel, .switchCtl, .calBusy, .calQuick, .calAmpIdx,
      .extClkUse, .hostCs_n, .gpioIn, .gpioOut, .gpioOe_n);
   pin_world world_u (.gpioOut, .gpioOe_n, .extDrv, .gpioIn);
   // shift register source of random values
   function [31:0] nextRand(input [31:0] s);
      nextRand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task stop_test;
      begin
         $display("checks %0d, mismatches %0d", checks_done, err_count);
         if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // inputs always move 1 ns after the rising edge
   task tick(input integer k);
      begin
         repeat (k) @(posedge sys_clk);
         #1;
      end
   endtask
   // strobes drop for a cycle between accesses, never re-raised in one step
   task wr(input [3:0] a, input [7:0] d);
      begin
         regWr = 1; regAddr = a; regWrData = d;
         tick(1);
         regWr = 0;
         tick(1);
      end
   endtask
   task rd(input [3:0] a, input [7:0] e);
      begin
         regRd = 1; regAddr = a;
         tick(1);
         regRd = 0;
         chk(regRdData, e);
         tick(1);
      end
   endtask
   // waits for a run, then returns its length in cycles
   task calLen(output integer len);
      begin
         t = 0;
         while (calBusy !== 1'b1 && t < 400) begin tick(1); t = t + 1; end
         len = 0;
         while (calBusy === 1'b1 && len < 400) begin tick(1); len = len + 1; end
         chk(t < 400 && len < 400, 1);
      end
   endtask
   // mode 0 counts run starts, mode 1 counts clock pin changes
   task countEv(input integer mode, input integer cyc, output integer cnt);
      reg last;
      begin
         cnt = 0;
         last = mode ? gpioOut[4] : calBusy;
         repeat (cyc) begin
            tick(1);
            if (mode ? (gpioOut[4] !== last) : (calBusy === 1'b1 && !last)) cnt = cnt + 1;
            last = mode ? gpioOut[4] : calBusy;
         end
      end
   endtask
   initial begin
      sys_clk = 0;
      forever #4 sys_clk = ~sys_clk;
   end
   // watchdog: the sequence needs well under 10000 cycles
   initial begin
      #(8 * 30000);
      err_count = err_count + 1;
      stop_test;
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      #1;
      arst_n = 1;
      tick(2); chk(calBusy, 1);
      calLen(n); chk(n >= FULL - 3 && n <= FULL + 1, 1);
      for (i = 0; i < 10; i = i + 1) rd(i[3:0], 8'h00);
      wr(4'hb, 8'hff); rd(4'hb, 8'h00);
      $display("end of test: reset values");
      for (i = 0; i < 8; i = i + 1) begin
         lfsr = nextRand(lfsr);
         extDrv = lfsr[14:8];
         wr(`REG_PIN_DIR, {1'b0, lfsr[6:0]});
         wr(`REG_PIN_VALUE, lfsr[23:16]);
         tick(3); chk(gpioOe_n, {1'b0, ~lfsr[6:0]});
         chk(gpioOut & lfsr[6:0], lfsr[22:16] & lfsr[6:0]);
         rd(`REG_PIN_VALUE, (lfsr[22:16] & lfsr[6:0]) | (lfsr[14:8] & ~lfsr[6:0]));
      end
      $display("end of test: pins");
      // pins and monitors are left quiet while runs are in progress
      wr(`REG_SWITCH, 8'h0f);
      for (i = 0; i < 2; i = i + 1) begin
         wr(`REG_CONTROL, i ? 8'h10 : 8'h12);
         tick(2); chk(switchCtl, 6'h30); chk(calQuick, !i);
         wr(`REG_CONTROL, i ? 8'h10 : 8'h12);
         calLen(n); chk(n >= (i ? FULL : QUICK) - 6 && n <= (i ? FULL : QUICK) + 1, 1);
         tick(4); chk(calBusy, 0); chk(switchCtl, 6'h0f);
         rd(`REG_CONTROL, i ? 8'h00 : 8'h02);
      end
      wr(`REG_CONTROL, 8'h06);
      countEv(0, 190, n); chk(n >= 3 && n <= 4, 1);
      wr(`REG_CONTROL, 8'h02); chk(calQuick, 1);
      countEv(0, 200, n); chk(n, 0);
      $display("end of test: calibration");
      wr(`REG_GAIN, 8'h2a); chk({scaleSel, inputGain}, 6'h2a);
      inClipA = 1; tick(3); rd(`REG_STATUS, 8'h01);
      tick(CLIP + 4); rd(`REG_GAIN, 8'h00); rd(`REG_STATUS, 8'h03);
      inClipA = 0; tick(2); wr(`REG_STATUS, 8'h02); rd(`REG_STATUS, 8'h00);
      wr(`REG_CONTROL, 8'h01); wr(`REG_GAIN, 8'h1a); chk({scaleSel, inputGain}, 6'h1a);
      inClipB = 1; tick(CLIP + 8); rd(`REG_GAIN, 8'h1a); rd(`REG_STATUS, 8'h01);
      inClipB = 0; wr(`REG_CONTROL, 8'h02);
      outSatNeg = 1; tick(3); rd(`REG_STATUS, 8'h04); outSatNeg = 0;
      hvNegLow = 1; tick(1); hvNegLow = 0; tick(3); rd(`REG_STATUS, 8'h18);
      calLen(n); chk(calQuick, 0);
      wr(`REG_STATUS, 8'h08); rd(`REG_STATUS, 8'h00);
      $display("end of test: flags");
      wr(`REG_PIN_DIR, 8'h3f); wr(`REG_SPECIAL_FUNCTION_CFG, 8'h0f); wr(`REG_GAIN, 8'h80);
      chk(gpioOut[1:0], 2'b10);
      outSatPos = 1; tick(5); chk(gpioOut[3], 1); outSatPos = 0;
      tick(4); chk(gpioOut[3], 0);
      wr(`REG_CONTROL, 8'h12); tick(2); chk(gpioOut[2], 1);
      calLen(n); tick(2); chk(gpioOut[2], 0);
      for (i = 0; i < 2; i = i + 1) begin
         wr(`REG_CONTROL, {2'b00, i[0], 5'h00});
         countEv(1, 1000, n); chk(n >= (i ? 1 : 15) && n <= (i ? 3 : 17), 1);
      end
      wr(`REG_PIN_DIR, 8'h2f); wr(`REG_SPECIAL_FUNCTION_CFG, 8'h10); chk(extClkUse, 1);
      wr(`REG_CHAIN_SEL, 8'h20);
      hostCs_n = 0; tick(2); chk(gpioOut[5], 0);
      hostCs_n = 1; tick(2); chk(gpioOut[5], 1);
      $display("end of test: pin functions");
      wr(`REG_GAIN, 8'h1a);
      softReset = 1; tick(1); softReset = 0;
      tick(2); chk(scaleSel, 2'b00); chk(calBusy, 1);
      rd(`REG_PIN_DIR, 8'h00);
      // run began 43 edges ago: four whole steps of FULL/9 cycles are done
      tick(40); chk(calAmpIdx, 43 / (FULL / 9));
      calLen(n);
      $display("end of test: soft reset");
      stop_test;
   end
endmodule // amp_supervision_tb_top
